// ---- include/ptc_pkg.sv ----
// package of offsets, fields, reset values and timing constants
package ptc_pkg;

  // ****************************************
  // register command codes
  // ****************************************
  localparam logic [7:0] CMD_WRITE_LOCK  = 8'h10;
  localparam logic [7:0] CMD_MIN_ON_BAL  = 8'hbe;
  localparam logic [7:0] CMD_MAX_DUTY    = 8'hbf;
  localparam logic [7:0] CMD_BOOT_REFR   = 8'hec;
  localparam logic [7:0] CMD_CUR_THRESH  = 8'hed;

  // ****************************************
  // reset values and writable masks
  // ****************************************
  localparam logic [7:0] RST_VALUE       = 8'h00;
  localparam logic [7:0] MASK_MIN_ON_BAL = 8'h0f;
  localparam logic [7:0] MASK_MAX_DUTY   = 8'h07;
  localparam logic [7:0] MASK_BOOT_REFR  = 8'h5f;
  localparam logic [7:0] MASK_CUR_THRESH = 8'h3f;
  localparam logic [7:0] MASK_WRITE_LOCK = 8'h80;
  localparam int         LOCK_BIT        = 7;

  // ****************************************
  // field positions
  // ****************************************
  localparam int MIN_ON_LSB     = 0;
  localparam int BAL_INTRA_BIT  = 2;
  localparam int BAL_INTER_BIT  = 3;
  localparam int INTERVAL_LSB   = 0;
  localparam int WIDTH_BIT      = 3;
  localparam int COUNT_BIT      = 4;
  localparam int BLANK_BIT      = 6;
  localparam int CONST_CUR_LSB  = 0;
  localparam int AVG_LIM_LSB    = 3;

  // ****************************************
  // times and cycle counts at 125 MHz
  // ****************************************
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int MIN_ON_340_NS  = 340;
  localparam int MIN_ON_280_NS  = 280;
  localparam int MIN_ON_220_NS  = 220;
  localparam int MIN_ON_180_NS  = 180;
  localparam int CYC_340 = (MIN_ON_340_NS * 1000 + CLK_PERIOD_PS - 1)
                           / CLK_PERIOD_PS;
  localparam int CYC_280 = (MIN_ON_280_NS * 1000 + CLK_PERIOD_PS - 1)
                           / CLK_PERIOD_PS;
  localparam int CYC_220 = (MIN_ON_220_NS * 1000 + CLK_PERIOD_PS - 1)
                           / CLK_PERIOD_PS;
  localparam int CYC_180 = (MIN_ON_180_NS * 1000 + CLK_PERIOD_PS - 1)
                           / CLK_PERIOD_PS;

  localparam int REFR_100_US    = 100;
  localparam int REFR_200_US    = 200;
  localparam int REFR_300_US    = 300;
  localparam int REFR_500_US    = 500;
  localparam int REFR_750_US    = 750;
  localparam int REFR_1000_US   = 1000;
  localparam int REFR_1500_US   = 1500;
  localparam int REFR_2000_US   = 2000;
  localparam int BLANK_1500_US  = 1500;
  localparam int BLANK_10000_US = 10000;
  localparam int CYC_PER_US     = 1000000 / CLK_PERIOD_PS;

  // ****************************************
  // pulse counts, fractions, duty in tenths of percent
  // ****************************************
  localparam logic [4:0] PULSE_INIT_LO  = 5'h03;
  localparam logic [4:0] PULSE_RUN_LO   = 5'h04;
  localparam logic [4:0] PULSE_INIT_HI  = 5'h10;
  localparam logic [4:0] PULSE_RUN_HI   = 5'h08;
  localparam logic [3:0] WIDTH_DIV_LO   = 4'hc;
  localparam logic [3:0] WIDTH_DIV_HI   = 4'h6;
  localparam logic [9:0] DUTY_917       = 10'h395;
  localparam logic [9:0] DUTY_958       = 10'h3be;
  localparam logic [9:0] DUTY_875       = 10'h36b;
  localparam logic [9:0] DUTY_833       = 10'h341;
  localparam logic [9:0] DUTY_792       = 10'h318;
  localparam logic [9:0] DUTY_750       = 10'h2ee;
  localparam logic [4:0] CONST_CUR_BASE_DV = 5'h18;
  localparam logic [4:0] AVG_LIM_BASE_DV   = 5'h1b;

endpackage

// ---- include/ptc_cfg_if.sv ----
// interface carrying the stored configuration bytes to the decoder
`timescale 1ns/1ps
interface ptc_cfg_if;
  logic [7:0] min_on_bal;
  logic [7:0] max_duty;
  logic [7:0] boot_refr;
  logic [7:0] cur_thresh;
  modport source (output min_on_bal, max_duty, boot_refr, cur_thresh);
  modport sink   (input  min_on_bal, max_duty, boot_refr, cur_thresh);
endinterface

// ---- design/ptc_decode.sv ----
// decoder turning configuration bytes into pwm core settings
`timescale 1ns/1ps
module ptc_decode (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // stored bytes
  ptc_cfg_if.sink          cfg,
  // decoded settings, registered
  output logic      [5:0]  min_on_cycles,
  output logic      [9:0]  max_duty_permille,
  output logic             max_duty_valid,
  output logic      [17:0] refresh_interval_cycles,
  output logic      [3:0]  refresh_width_div,
  output logic      [4:0]  refresh_pulses_init,
  output logic      [4:0]  refresh_pulses_run,
  output logic      [20:0] blank_cycles,
  output logic      [4:0]  const_cur_dv,
  output logic      [4:0]  avg_lim_dv
);

  // ****************************************
  // next values
  // ****************************************
  logic [5:0]  min_on_next;
  logic [9:0]  duty_next;
  logic        duty_valid_next;
  logic [17:0] interval_next;
  logic [3:0]  width_next;
  logic [4:0]  init_next;
  logic [4:0]  run_next;
  logic [20:0] blank_next;
  logic [4:0]  const_cur_next;
  logic [4:0]  avg_lim_next;
  int          interval_us;

  always_comb begin
    interval_us = ptc_pkg::REFR_500_US;
    case (cfg.min_on_bal[ptc_pkg::MIN_ON_LSB +: 2])
      2'h0:    min_on_next = 6'(ptc_pkg::CYC_340);
      2'h1:    min_on_next = 6'(ptc_pkg::CYC_280);
      2'h2:    min_on_next = 6'(ptc_pkg::CYC_220);
      2'h3:    min_on_next = 6'(ptc_pkg::CYC_180);
      default: min_on_next = 6'(ptc_pkg::CYC_340);
    endcase
    duty_valid_next = 1'b1;
    case (cfg.max_duty[2:0])
      3'h0:    duty_next = ptc_pkg::DUTY_917;
      3'h1:    duty_next = ptc_pkg::DUTY_958;
      3'h2:    duty_next = ptc_pkg::DUTY_875;
      3'h3:    duty_next = ptc_pkg::DUTY_833;
      3'h4:    duty_next = ptc_pkg::DUTY_792;
      3'h5:    duty_next = ptc_pkg::DUTY_750;
      default: begin
        // unassigned codes fall back to the reset duty and are flagged
        duty_next       = ptc_pkg::DUTY_917;
        duty_valid_next = 1'b0;
      end
    endcase
    case (cfg.boot_refr[ptc_pkg::INTERVAL_LSB +: 3])
      3'h0:    interval_us = ptc_pkg::REFR_500_US;
      3'h1:    interval_us = ptc_pkg::REFR_100_US;
      3'h2:    interval_us = ptc_pkg::REFR_200_US;
      3'h3:    interval_us = ptc_pkg::REFR_300_US;
      3'h4:    interval_us = ptc_pkg::REFR_750_US;
      3'h5:    interval_us = ptc_pkg::REFR_1000_US;
      3'h6:    interval_us = ptc_pkg::REFR_1500_US;
      3'h7:    interval_us = ptc_pkg::REFR_2000_US;
      default: interval_us = ptc_pkg::REFR_500_US;
    endcase
    interval_next = 18'(interval_us * ptc_pkg::CYC_PER_US);
    width_next = cfg.boot_refr[ptc_pkg::WIDTH_BIT] ?
                 ptc_pkg::WIDTH_DIV_HI : ptc_pkg::WIDTH_DIV_LO;
    init_next  = cfg.boot_refr[ptc_pkg::COUNT_BIT] ?
                 ptc_pkg::PULSE_INIT_HI : ptc_pkg::PULSE_INIT_LO;
    run_next   = cfg.boot_refr[ptc_pkg::COUNT_BIT] ?
                 ptc_pkg::PULSE_RUN_HI : ptc_pkg::PULSE_RUN_LO;
    blank_next = cfg.boot_refr[ptc_pkg::BLANK_BIT] ?
                 21'(ptc_pkg::BLANK_10000_US * ptc_pkg::CYC_PER_US) :
                 21'(ptc_pkg::BLANK_1500_US * ptc_pkg::CYC_PER_US);
    const_cur_next = ptc_pkg::CONST_CUR_BASE_DV -
      {2'h0, cfg.cur_thresh[ptc_pkg::CONST_CUR_LSB +: 3]};
    avg_lim_next   = ptc_pkg::AVG_LIM_BASE_DV -
      {2'h0, cfg.cur_thresh[ptc_pkg::AVG_LIM_LSB +: 3]};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      min_on_cycles           <= 6'(ptc_pkg::CYC_340);
      max_duty_permille       <= ptc_pkg::DUTY_917;
      max_duty_valid          <= 1'b1;
      refresh_interval_cycles <= 18'(ptc_pkg::REFR_500_US *
                                     ptc_pkg::CYC_PER_US);
      refresh_width_div       <= ptc_pkg::WIDTH_DIV_LO;
      refresh_pulses_init     <= ptc_pkg::PULSE_INIT_LO;
      refresh_pulses_run      <= ptc_pkg::PULSE_RUN_LO;
      blank_cycles            <= 21'(ptc_pkg::BLANK_1500_US *
                                     ptc_pkg::CYC_PER_US);
      const_cur_dv            <= ptc_pkg::CONST_CUR_BASE_DV;
      avg_lim_dv              <= ptc_pkg::AVG_LIM_BASE_DV;
    end else begin
      min_on_cycles           <= min_on_next;
      max_duty_permille       <= duty_next;
      max_duty_valid          <= duty_valid_next;
      refresh_interval_cycles <= interval_next;
      refresh_width_div       <= width_next;
      refresh_pulses_init     <= init_next;
      refresh_pulses_run      <= run_next;
      blank_cycles            <= blank_next;
      const_cur_dv            <= const_cur_next;
      avg_lim_dv              <= avg_lim_next;
    end
  end

endmodule

// ---- design/ptc_regs.sv ----
// pwm timing configuration register bank with decoded settings
`timescale 1ns/1ps
module ptc_regs (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // command port from the management serial interface
  input  wire logic        cmd_write,
  input  wire logic        cmd_read,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [7:0]  cmd_wdata,
  output logic      [7:0]  cmd_rdata,
  output logic             cmd_rvalid,
  output logic             cmd_hit,
  // operating mode from the pwm core
  input  wire logic        boost_mode,
  // minimum on-time and balancing
  output logic      [5:0]  min_on_cycles,
  output logic      [5:0]  min_on_high_side,
  output logic      [5:0]  min_on_low_side,
  output logic             balance_intra_en,
  output logic             balance_inter_en,
  // maximum duty
  output logic      [9:0]  duty_limit_high_side,
  output logic      [9:0]  duty_limit_low_side,
  output logic      [9:0]  duty_limit_flyback,
  output logic             max_duty_valid,
  // boot refresh and phase-drop blanking
  output logic      [17:0] refresh_interval_cycles,
  output logic      [3:0]  refresh_width_div,
  output logic      [4:0]  refresh_pulses_init,
  output logic      [4:0]  refresh_pulses_run,
  output logic      [20:0] blank_cycles,
  // threshold codes and decoded levels in tenths of a volt
  output logic      [2:0]  constant_current_loop_code,
  output logic      [2:0]  average_current_limit_code,
  output logic      [4:0]  constant_current_loop_dv,
  output logic      [4:0]  average_current_limit_dv
);

  // ****************************************
  // register state
  // ****************************************
  logic [7:0] lock_reg;
  logic [7:0] lock_next;
  logic [7:0] min_on_bal_reg;
  logic [7:0] min_on_bal_next;
  logic [7:0] max_duty_reg;
  logic [7:0] max_duty_next;
  logic [7:0] boot_refr_reg;
  logic [7:0] boot_refr_next;
  logic [7:0] cur_thresh_reg;
  logic [7:0] cur_thresh_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;
  logic       hit_reg;
  logic       hit_next;
  logic       locked;
  logic       known;

  ptc_cfg_if cfg ();

  assign cfg.min_on_bal = min_on_bal_reg;
  assign cfg.max_duty   = max_duty_reg;
  assign cfg.boot_refr  = boot_refr_reg;
  assign cfg.cur_thresh = cur_thresh_reg;
  assign locked = lock_reg[ptc_pkg::LOCK_BIT];

  // ****************************************
  // write, read and decode of commands
  // ****************************************
  always_comb begin
    lock_next       = lock_reg;
    min_on_bal_next = min_on_bal_reg;
    max_duty_next   = max_duty_reg;
    boot_refr_next  = boot_refr_reg;
    cur_thresh_next = cur_thresh_reg;
    known           = 1'b1;
    rdata_next      = 8'h00;
    case (cmd_code)
      ptc_pkg::CMD_WRITE_LOCK:  rdata_next = lock_reg;
      ptc_pkg::CMD_MIN_ON_BAL:  rdata_next = min_on_bal_reg;
      ptc_pkg::CMD_MAX_DUTY:    rdata_next = max_duty_reg;
      ptc_pkg::CMD_BOOT_REFR:   rdata_next = boot_refr_reg;
      ptc_pkg::CMD_CUR_THRESH:  rdata_next = cur_thresh_reg;
      default:                  known      = 1'b0;
    endcase
    // the lock register itself stays writable so software can unlock
    if (cmd_write && cmd_code == ptc_pkg::CMD_WRITE_LOCK) begin
      lock_next = cmd_wdata & ptc_pkg::MASK_WRITE_LOCK;
    end
    if (cmd_write && !locked) begin
      case (cmd_code)
        ptc_pkg::CMD_MIN_ON_BAL:
          min_on_bal_next = cmd_wdata & ptc_pkg::MASK_MIN_ON_BAL;
        ptc_pkg::CMD_MAX_DUTY:
          max_duty_next = cmd_wdata & ptc_pkg::MASK_MAX_DUTY;
        ptc_pkg::CMD_BOOT_REFR:
          boot_refr_next = cmd_wdata & ptc_pkg::MASK_BOOT_REFR;
        ptc_pkg::CMD_CUR_THRESH:
          cur_thresh_next = cmd_wdata & ptc_pkg::MASK_CUR_THRESH;
        default: ;
      endcase
    end
    rvalid_next = cmd_read;
    hit_next    = (cmd_read || cmd_write) && known;
    if (!cmd_read) begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lock_reg       <= ptc_pkg::RST_VALUE;
      min_on_bal_reg <= ptc_pkg::RST_VALUE;
      max_duty_reg   <= ptc_pkg::RST_VALUE;
      boot_refr_reg  <= ptc_pkg::RST_VALUE;
      cur_thresh_reg <= ptc_pkg::RST_VALUE;
      rdata_reg      <= 8'h00;
      rvalid_reg     <= 1'b0;
      hit_reg        <= 1'b0;
    end else begin
      lock_reg       <= lock_next;
      min_on_bal_reg <= min_on_bal_next;
      max_duty_reg   <= max_duty_next;
      boot_refr_reg  <= boot_refr_next;
      cur_thresh_reg <= cur_thresh_next;
      rdata_reg      <= rdata_next;
      rvalid_reg     <= rvalid_next;
      hit_reg        <= hit_next;
    end
  end

  assign cmd_rdata  = rdata_reg;
  assign cmd_rvalid = rvalid_reg;
  assign cmd_hit    = hit_reg;

  // ****************************************
  // decode into pwm settings
  // ****************************************
  logic [5:0] min_on_dec;
  logic [9:0] duty_dec;

  ptc_decode u_decode (
    .clock                   (clock),
    .rst                     (rst),
    .cfg                     (cfg.sink),
    .min_on_cycles           (min_on_dec),
    .max_duty_permille       (duty_dec),
    .max_duty_valid          (max_duty_valid),
    .refresh_interval_cycles (refresh_interval_cycles),
    .refresh_width_div       (refresh_width_div),
    .refresh_pulses_init     (refresh_pulses_init),
    .refresh_pulses_run      (refresh_pulses_run),
    .blank_cycles            (blank_cycles),
    .const_cur_dv            (constant_current_loop_dv),
    .avg_lim_dv              (average_current_limit_dv)
  );

  // ****************************************
  // steering by operating mode
  // ****************************************
  logic [5:0] on_hs_next;
  logic [5:0] on_ls_next;
  logic [9:0] duty_hs_next;
  logic [9:0] duty_ls_next;
  logic [5:0] on_hs_reg;
  logic [5:0] on_ls_reg;
  logic [9:0] duty_hs_reg;
  logic [9:0] duty_ls_reg;
  logic [9:0] duty_fb_reg;
  logic [5:0] on_reg;
  logic       bal_intra_reg;
  logic       bal_inter_reg;
  logic [2:0] const_cur_code_reg;
  logic [2:0] avg_lim_code_reg;

  // a switch that is not the main switch in this mode gets zero limits
  always_comb begin
    on_hs_next   = boost_mode ? 6'h00 : min_on_dec;
    on_ls_next   = boost_mode ? min_on_dec : 6'h00;
    duty_hs_next = boost_mode ? 10'h000 : duty_dec;
    duty_ls_next = boost_mode ? duty_dec : 10'h000;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      on_hs_reg     <= 6'h00;
      on_ls_reg     <= 6'h00;
      duty_hs_reg   <= 10'h000;
      duty_ls_reg   <= 10'h000;
      duty_fb_reg   <= ptc_pkg::DUTY_917;
      on_reg        <= 6'(ptc_pkg::CYC_340);
      bal_intra_reg <= 1'b0;
      bal_inter_reg <= 1'b0;
      const_cur_code_reg <= 3'h0;
      avg_lim_code_reg   <= 3'h0;
    end else begin
      on_hs_reg     <= on_hs_next;
      on_ls_reg     <= on_ls_next;
      duty_hs_reg   <= duty_hs_next;
      duty_ls_reg   <= duty_ls_next;
      duty_fb_reg   <= duty_dec;
      on_reg        <= min_on_dec;
      bal_intra_reg <= min_on_bal_reg[ptc_pkg::BAL_INTRA_BIT];
      bal_inter_reg <= min_on_bal_reg[ptc_pkg::BAL_INTER_BIT];
      const_cur_code_reg <=
        cur_thresh_reg[ptc_pkg::CONST_CUR_LSB +: 3];
      avg_lim_code_reg   <=
        cur_thresh_reg[ptc_pkg::AVG_LIM_LSB +: 3];
    end
  end

  assign min_on_cycles              = on_reg;
  assign min_on_high_side           = on_hs_reg;
  assign min_on_low_side            = on_ls_reg;
  assign duty_limit_high_side       = duty_hs_reg;
  assign duty_limit_low_side        = duty_ls_reg;
  assign duty_limit_flyback         = duty_fb_reg;
  assign balance_intra_en           = bal_intra_reg;
  assign balance_inter_en           = bal_inter_reg;
  assign constant_current_loop_code = const_cur_code_reg;
  assign average_current_limit_code = avg_lim_code_reg;

endmodule

// ---- dv/ptc_regs_checker.sv ----
// concurrent checks on the ports of the configuration register bank
`timescale 1ns/1ps
module ptc_regs_checker (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // command port
  input wire logic        cmd_write,
  input wire logic        cmd_read,
  input wire logic [7:0]  cmd_code,
  input wire logic [7:0]  cmd_wdata,
  input wire logic [7:0]  cmd_rdata,
  input wire logic        cmd_rvalid,
  input wire logic        cmd_hit,
  // settings
  input wire logic        boost_mode,
  input wire logic [5:0]  min_on_cycles,
  input wire logic [5:0]  min_on_high_side,
  input wire logic [5:0]  min_on_low_side,
  input wire logic        balance_intra_en,
  input wire logic [4:0]  refresh_pulses_init,
  input wire logic [4:0]  refresh_pulses_run,
  input wire logic [2:0]  constant_current_loop_code,
  input wire logic [2:0]  average_current_limit_code,
  input wire logic [4:0]  constant_current_loop_dv,
  input wire logic [4:0]  average_current_limit_dv
);
  // ****
  // lock mirror and readable-bit mask
  // ****
  logic       lock_reg;
  logic       lock_next;
  logic [7:0] rd_mask;
  logic       req_known;
  always_comb begin
    lock_next = lock_reg;
    if (cmd_write && cmd_code == ptc_pkg::CMD_WRITE_LOCK) begin
      lock_next = cmd_wdata[ptc_pkg::LOCK_BIT];
    end
    case (cmd_code)
      ptc_pkg::CMD_WRITE_LOCK: rd_mask = ptc_pkg::MASK_WRITE_LOCK;
      ptc_pkg::CMD_MIN_ON_BAL: rd_mask = ptc_pkg::MASK_MIN_ON_BAL;
      ptc_pkg::CMD_MAX_DUTY:   rd_mask = ptc_pkg::MASK_MAX_DUTY;
      ptc_pkg::CMD_BOOT_REFR:  rd_mask = ptc_pkg::MASK_BOOT_REFR;
      ptc_pkg::CMD_CUR_THRESH: rd_mask = ptc_pkg::MASK_CUR_THRESH;
      default:                 rd_mask = 8'h00;
    endcase
  end
  // unknown codes have an empty mask, so their reads must return zero
  assign req_known = (cmd_read || cmd_write) && (rd_mask != 8'h00);
  always_ff @(posedge clock) begin
    lock_reg <= rst ? 1'b0 : lock_next;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_read_valid: assert property (1'b1 |=> cmd_rvalid == $past(cmd_read))
    else $error("read valid not one cycle after read");
  a_hit_known: assert property (1'b1 |=> cmd_hit == $past(req_known))
    else $error("hit flag wrong for command code");
  a_reserved_bits: assert property (cmd_read |=>
    (cmd_rdata & ~$past(rd_mask)) == 8'h00)
    else $error("reserved or unknown bits read nonzero");
  a_buck_low_zero: assert property (!boost_mode [*4] |->
    min_on_low_side == 6'h00) else $error("low side minimum set in buck");
  a_buck_high_follow: assert property (
    (!boost_mode && $stable(min_on_cycles)) [*4] |->
    min_on_high_side == min_on_cycles)
    else $error("high side minimum not steered in buck");
  a_boost_high_zero: assert property (boost_mode [*4] |->
    min_on_high_side == 6'h00) else $error("high side minimum set in boost");
  a_pulse_pair: assert property (
    refresh_pulses_init == ptc_pkg::PULSE_INIT_LO ?
      refresh_pulses_run == ptc_pkg::PULSE_RUN_LO :
      (refresh_pulses_init == ptc_pkg::PULSE_INIT_HI &&
       refresh_pulses_run == ptc_pkg::PULSE_RUN_HI))
    else $error("refresh pulse counts not a legal pair");
  a_const_cur_level: assert property (
    $stable(constant_current_loop_code) [*3] |->
    constant_current_loop_dv == 5'h18 - constant_current_loop_code)
    else $error("constant current threshold level wrong");
  a_avg_lim_level: assert property (
    $stable(average_current_limit_code) [*3] |->
    average_current_limit_dv == 5'h1b - average_current_limit_code)
    else $error("average limit threshold level wrong");
  a_lock_hold: assert property (
    lock_reg && cmd_write && cmd_code == ptc_pkg::CMD_CUR_THRESH |=> ##1
    $stable(constant_current_loop_code) && $stable(average_current_limit_code))
    else $error("locked write changed threshold codes");
  a_code_update: assert property (
    !lock_reg && cmd_write && cmd_code == ptc_pkg::CMD_CUR_THRESH |-> ##2
    constant_current_loop_code == $past(cmd_wdata[2:0], 2))
    else $error("threshold code not taken from write");
  a_balance_update: assert property (
    !lock_reg && cmd_write && cmd_code == ptc_pkg::CMD_MIN_ON_BAL |-> ##2
    balance_intra_en == $past(cmd_wdata[2], 2))
    else $error("balance enable not taken from write");

  c_locked_write: cover property (lock_reg && cmd_write);
  c_boost_min_on: cover property (boost_mode && min_on_low_side != 6'h00);
  c_unknown_read: cover property (cmd_read && rd_mask == 8'h00);
endmodule

bind ptc_regs ptc_regs_checker u_chk (.*);

// ---- dv/ptc_host.sv ----
// management controller model issuing single-byte commands
`timescale 1ns/1ps
module ptc_host (
  // clock
  input wire logic        clock,
  // command port
  output logic            cmd_write,
  output logic            cmd_read,
  output logic [7:0]      cmd_code,
  output logic [7:0]      cmd_wdata,
  input wire logic [7:0]  cmd_rdata,
  input wire logic        cmd_hit
);
  // idle lines start at zero, then carry the inverted code (and after a write the inverted data) so stale values are never mistaken
  initial begin
    cmd_write = 1'b0;
    cmd_read  = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(negedge clock);
    cmd_write = 1'b1;
    cmd_code  = code;
    cmd_wdata = data;
    @(negedge clock);
    cmd_write = 1'b0;
    cmd_code  = ~code;
    cmd_wdata = ~data;
  endtask
  task automatic rd(input logic [7:0] code, output logic [7:0] d,
                    output logic h);
    @(negedge clock);
    cmd_read = 1'b1;
    cmd_code = code;
    @(negedge clock);
    d        = cmd_rdata;
    h        = cmd_hit;
    cmd_read = 1'b0;
    cmd_code = ~code;
  endtask
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module tb_top;
  logic        clock, rst, boost_mode, cmd_write, cmd_read, cmd_rvalid;
  logic        cmd_hit, balance_intra_en, balance_inter_en, max_duty_valid;
  logic [7:0]  cmd_code, cmd_wdata, cmd_rdata, d;
  logic        h;
  logic [5:0]  min_on_cycles, min_on_high_side, min_on_low_side;
  logic [9:0]  duty_limit_high_side, duty_limit_low_side, duty_limit_flyback;
  logic [17:0] refresh_interval_cycles;
  logic [3:0]  refresh_width_div;
  logic [4:0]  refresh_pulses_init, refresh_pulses_run;
  logic [4:0]  constant_current_loop_dv, average_current_limit_dv;
  logic [20:0] blank_cycles;
  logic [2:0]  constant_current_loop_code, average_current_limit_code;
  logic [7:0]  v;
  int          miscompares = 0;
  int          check_count = 0;
  int on_cyc[4] = '{ptc_pkg::CYC_340, ptc_pkg::CYC_280, ptc_pkg::CYC_220,
                    ptc_pkg::CYC_180};
  logic [9:0] duty[6] = '{ptc_pkg::DUTY_917, ptc_pkg::DUTY_958,
    ptc_pkg::DUTY_875, ptc_pkg::DUTY_833, ptc_pkg::DUTY_792,
    ptc_pkg::DUTY_750};
  int refr_us[8] = '{ptc_pkg::REFR_500_US, ptc_pkg::REFR_100_US,
    ptc_pkg::REFR_200_US, ptc_pkg::REFR_300_US, ptc_pkg::REFR_750_US,
    ptc_pkg::REFR_1000_US, ptc_pkg::REFR_1500_US, ptc_pkg::REFR_2000_US};

  ptc_host u_host (.clock(clock), .cmd_write(cmd_write), .cmd_read(cmd_read),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_hit(cmd_hit));
  ptc_regs u_dut (.*);

  initial clock = 1'b0;
  always #4 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // decoded outputs trail the write by up to three register stages
  task automatic wr_settle(input logic [7:0] code, input logic [7:0] data);
    u_host.wr(code, data);
    repeat (4) @(negedge clock);
  endtask
  task automatic rd_chk(input logic [7:0] code, input logic [7:0] exp);
    u_host.rd(code, d, h);
    check(d, exp);
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    boost_mode = 1'b0;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    // ****
    // reset state
    // ****
    rd_chk(ptc_pkg::CMD_MIN_ON_BAL, 8'h00);
    rd_chk(ptc_pkg::CMD_BOOT_REFR, 8'h00);
    check(duty_limit_flyback, ptc_pkg::DUTY_917);
    check(min_on_cycles, on_cyc[0]);
    // ****
    // minimum on-time, balancing and mode steering
    // ****
    for (int i = 0; i < 4; i++) begin
      boost_mode = i[0];
      v = 8'hf0 | 8'(i * 5);
      wr_settle(ptc_pkg::CMD_MIN_ON_BAL, v);
      rd_chk(ptc_pkg::CMD_MIN_ON_BAL, v & 8'h0f);
      check(min_on_cycles, on_cyc[i]);
      check({balance_inter_en, balance_intra_en}, i);
      check(i[0] ? min_on_low_side : min_on_high_side, on_cyc[i]);
      check(i[0] ? min_on_high_side : min_on_low_side, 0);
    end
    // ****
    // maximum duty; unassigned codes are never written
    // ****
    for (int i = 0; i < 6; i++) begin
      boost_mode = i[0];
      wr_settle(ptc_pkg::CMD_MAX_DUTY, 8'hf8 | 8'(i));
      rd_chk(ptc_pkg::CMD_MAX_DUTY, 8'(i));
      check(duty_limit_flyback, duty[i]);
      check(i[0] ? duty_limit_low_side : duty_limit_high_side, duty[i]);
      check(i[0] ? duty_limit_high_side : duty_limit_low_side, 0);
      check(max_duty_valid, 1);
    end
    // ****
    // boot refresh and blanking
    // ****
    for (int i = 0; i < 8; i++) begin
      v = {1'b1, i[2], 1'b1, i[1], i[0], i[2:0]};
      wr_settle(ptc_pkg::CMD_BOOT_REFR, v);
      rd_chk(ptc_pkg::CMD_BOOT_REFR, v & 8'h5f);
      check(refresh_interval_cycles, refr_us[i] * ptc_pkg::CYC_PER_US);
      check(refresh_width_div, i[0] ? ptc_pkg::WIDTH_DIV_HI
                                    : ptc_pkg::WIDTH_DIV_LO);
      check(refresh_pulses_init, i[1] ? ptc_pkg::PULSE_INIT_HI
                                      : ptc_pkg::PULSE_INIT_LO);
      check(refresh_pulses_run, i[1] ? ptc_pkg::PULSE_RUN_HI
                                     : ptc_pkg::PULSE_RUN_LO);
      check(blank_cycles, (i[2] ? ptc_pkg::BLANK_10000_US
        : ptc_pkg::BLANK_1500_US) * ptc_pkg::CYC_PER_US);
    end
    // ****
    // threshold codes
    // ****
    for (int i = 0; i < 8; i++) begin
      v = {2'b11, 3'(7 - i), i[2:0]};
      wr_settle(ptc_pkg::CMD_CUR_THRESH, v);
      rd_chk(ptc_pkg::CMD_CUR_THRESH, v & 8'h3f);
      check(constant_current_loop_code, i);
      check(average_current_limit_code, 7 - i);
      check(constant_current_loop_dv, 24 - i);
      check(average_current_limit_dv, 20 + i);
    end
    // ****
    // write lock, then an unknown code
    // ****
    wr_settle(ptc_pkg::CMD_WRITE_LOCK, 8'hff);
    rd_chk(ptc_pkg::CMD_WRITE_LOCK, 8'h80);
    wr_settle(ptc_pkg::CMD_CUR_THRESH, 8'h00);
    wr_settle(ptc_pkg::CMD_MIN_ON_BAL, 8'h00);
    rd_chk(ptc_pkg::CMD_CUR_THRESH, 8'h07);
    rd_chk(ptc_pkg::CMD_MIN_ON_BAL, 8'h0f);
    check(constant_current_loop_code, 7);
    wr_settle(ptc_pkg::CMD_WRITE_LOCK, 8'h00);
    wr_settle(ptc_pkg::CMD_CUR_THRESH, 8'h00);
    rd_chk(ptc_pkg::CMD_CUR_THRESH, 8'h00);
    u_host.rd(8'h55, d, h);
    check({h, d}, 0);
    report_and_stop();
  end
endmodule
